// ### shf_top.sv
// Summary of operation
// - per-spreader channel type in parameter memory
// - request memory drives activation and stream count
// - sync and pilot types never fetch input
// - per-unit header then payload prepared by software
// - DPCH copies slot mask, DTX, CM type, pointer
// - per-type header copy sets for common channels
// - HS-PDSCH and HS-SCCH header copy sets
// - active fetching spreader fetches once per unit
// - static fields never touched by header fetch
// - colliding header and software writes both land
// - two alternating header copies per spreader
// - sub-frames of 2 ms, 7680 chips
// - dummy spreader supplies group gain and weights
// - P-CCPCH STTD secondary stream enable
// - HS-PDSCH timing independent of neighbour spreaders
// - P-CCPCH diversity independent of neighbour timing
`timescale 1ns/1ns
`include "shf_cfg.svh"

module shf_fifo #(
  parameter int W = 32,
  parameter int D = 8
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  // drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [0:D-1]; // storage words
  logic [AW-1:0] wp_q; // write pointer
  logic [AW-1:0] rp_q; // read pointer
  logic [AW:0] cnt_q; // fill level
  logic [AW:0] cnt_d;
  logic push;
  logic pop;

  assign push = i_valid & o_ready;
  assign pop = o_valid & i_ready;
  assign o_valid = (cnt_q != '0);
  assign o_data = mem[rp_q];

  // level bookkeeping
  always_comb begin
    cnt_d = cnt_q;
    if (push & ~pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop & ~push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // pointers and level; ready is registered so it is glitch free at the pin
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      o_ready <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      o_ready <= (cnt_d != (AW+1)'(D));
      if (push) begin
        wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
      end
    end
  end

  // data storage, no reset needed
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp_q] <= i_data;
    end
  end
endmodule // shf_fifo

module shf_top (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // chip strobe from the timing block, same clock
  input wire logic i_chip_tick,
  // header word stream from input memory
  input wire logic i_hdr_valid,
  input wire logic [31:0] i_hdr_data,
  output logic o_hdr_ready,
  // header fetch request toward input memory
  output logic o_fetch_req,
  output logic [`SHF_SPR_W-1:0] o_fetch_spr,
  // per-spreader datapath controls
  output logic [`SHF_NSPR-1:0] o_spr_active,
  output logic [`SHF_NSPR-1:0] o_spr_dual,
  output logic [`SHF_NSPR-1:0] o_sttd_en,
  output logic [`SHF_NSPR*16-1:0] o_spr_gain,
  output logic [`SHF_NSPR*32-1:0] o_spr_weight,
  output logic [`SHF_NSPR*32-1:0] o_hdr_cur
);
  localparam int NS = `SHF_NSPR;

  // channel type of a configuration word
  function automatic shf_pkg::shf_chan_t cfg_type(input logic [31:0] w);
    cfg_type = shf_pkg::shf_chan_t'(w[`SHF_CFG_TYPE]);
  endfunction

  // sync and pilot spreaders never read input memory
  function automatic logic is_fetching(input shf_pkg::shf_chan_t t);
    case (t)
      shf_pkg::CH_PSCH, shf_pkg::CH_SSCH, shf_pkg::CH_PCPICH, shf_pkg::CH_SCPICH,
      shf_pkg::CH_DUMMY: is_fetching = 1'b0;
      default: is_fetching = 1'b1;
    endcase
  endfunction

  // header bits that a type copies into its bank word
  function automatic logic [31:0] hdr_mask(input shf_pkg::shf_chan_t t);
    case (t)
      shf_pkg::CH_DPCH: hdr_mask = `SHF_HM_HI | `SHF_HM_DTX | `SHF_HM_CMT | `SHF_HM_NBP;
      shf_pkg::CH_MICH, shf_pkg::CH_PICH, shf_pkg::CH_PCCPCH:
        hdr_mask = `SHF_HM_HI | `SHF_HM_DTX;
      shf_pkg::CH_SCCPCH: hdr_mask = `SHF_HM_DTX | `SHF_HM_NBP | `SHF_HM_HI;
      shf_pkg::CH_FDPCH: hdr_mask = `SHF_HM_HI | `SHF_HM_DTX;
      shf_pkg::CH_AICH, shf_pkg::CH_EAICH, shf_pkg::CH_EHICH, shf_pkg::CH_EAGCH:
        hdr_mask = `SHF_HM_DTX;
      shf_pkg::CH_HSPDSCH: hdr_mask = `SHF_HM_HI | `SHF_HM_MOD | `SHF_HM_DTX | `SHF_HM_DIV
                                      | `SHF_HM_NBP;
      shf_pkg::CH_HSSCCH: hdr_mask = `SHF_HM_DIV | `SHF_HM_DTX;
      default: hdr_mask = 32'h0000_0000;
    endcase
  endfunction

  // types whose gain arrives in the header each unit
  function automatic logic hdr_gain(input shf_pkg::shf_chan_t t);
    case (t)
      shf_pkg::CH_MICH, shf_pkg::CH_PICH, shf_pkg::CH_PCCPCH, shf_pkg::CH_SCCPCH: hdr_gain = 1'b1;
      default: hdr_gain = 1'b0;
    endcase
  endfunction

  // chip position inside the spreader's own frame, from its own offset only
  function automatic logic [15:0] local_pos(input logic [15:0] cnt, input logic [7:0] ofs);
    logic [23:0] off;
    logic [15:0] o16;
    off = 24'(ofs) * 24'(`SHF_OFS_UNIT);
    o16 = (off >= 24'(`SHF_FRAME_CHIPS)) ? 16'h0000 : off[15:0];
    local_pos = (cnt >= o16) ? 16'(cnt - o16) : 16'(cnt + `SHF_FRAME_CHIPS - o16);
  endfunction

  // unit boundary: access slot, frame or sub-frame by type
  function automatic logic unit_edge(input shf_pkg::shf_chan_t t, input logic [15:0] pos);
    case (t)
      shf_pkg::CH_AICH, shf_pkg::CH_EAICH: unit_edge = ((pos % `SHF_ASLOT_CHIPS) == 16'h0000);
      shf_pkg::CH_HSPDSCH, shf_pkg::CH_HSSCCH, shf_pkg::CH_EHICH, shf_pkg::CH_EAGCH,
      shf_pkg::CH_DUMMY: unit_edge = ((pos % `SHF_SUBFRAME_CHIPS) == 16'h0000);
      default: unit_edge = (pos == 16'h0000);
    endcase
  endfunction

  // parameter memory index of a spreader word
  function automatic logic [5:0] pm_idx(input logic [`SHF_SPR_W-1:0] s, input logic [2:0] w);
    pm_idx = {s, w};
  endfunction

  logic [31:0] pm_q [0:`SHF_PM_DEPTH-1]; // spreader_param_mem, all spreaders
  logic [31:0] rm_q [0:`SHF_RM_DEPTH-1]; // spreader_request_mem, one word each
  logic [15:0] chip_cnt_q; // shared chip counter within the frame
  logic [NS-1:0] edge_w; // unit boundary this chip, per spreader
  logic [NS-1:0] act_q; // spreader datapath running
  logic [NS-1:0] dual_q; // two output streams
  logic [NS-1:0] sel_q; // bank in use by the datapath
  logic [NS-1:0] pend_q; // header fetch owed
  logic [NS-1:0] pend_set; // new fetch owed this cycle
  logic [NS-1:0] pend_clr; // fetch started this cycle
  shf_pkg::shf_fetch_st_t fst_q; // fetch sequencer state
  logic [`SHF_SPR_W-1:0] fspr_q; // spreader being fetched
  logic [31:0] fword_q; // header word captured from the stream
  logic fifo_valid;
  logic [31:0] fifo_data;
  logic fifo_pop;
  logic hdr_wr; // header write owns the memory port
  logic [5:0] hdr_addr;
  logic [31:0] hdr_val;
  logic apb_acc; // access phase not yet answered
  logic [11:0] a12;
  logic hi_zero;
  logic sw_pm_wr;
  logic sw_rm_wr;
  logic stall; // software write held back a cycle
  logic map_ok;
  logic [31:0] rd_val;

  // header words wait here so input memory can run ahead of the sequencer
  shf_fifo #(.W(32), .D(8)) u_hdr_fifo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_valid(i_hdr_valid),
    .o_ready(o_hdr_ready),
    .i_data(i_hdr_data),
    .o_valid(fifo_valid),
    .i_ready(fifo_pop),
    .o_data(fifo_data)
  );

  // frame chip counter, advanced by the chip strobe
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      chip_cnt_q <= 16'h0000;
    end else if (i_chip_tick) begin
      chip_cnt_q <= (chip_cnt_q == 16'(`SHF_FRAME_CHIPS - 16'h0001)) ? 16'h0000
                    : 16'(chip_cnt_q + 16'h0001);
    end
  end

  // unit boundaries; each spreader looks only at its own offset
  always_comb begin
    for (int s = 0; s < NS; s++) begin
      edge_w[s] = i_chip_tick & unit_edge(cfg_type(pm_q[pm_idx(3'(s), `SHF_PMW_CFG)]),
        local_pos(chip_cnt_q, pm_q[pm_idx(3'(s), `SHF_PMW_TIM)][`SHF_TIM_OFS]));
    end
  end

  // state change and stream count follow request memory at the unit boundary
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      act_q <= '0;
      dual_q <= '0;
    end else begin
      for (int s = 0; s < NS; s++) begin
        if (edge_w[s]) begin
          act_q[s] <= rm_q[s][`SHF_RQ_ACT];
          dual_q[s] <= rm_q[s][`SHF_RQ_DUAL];
        end
      end
    end
  end

  // bank flip: the unit now starting uses the copy fetched for it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel_q <= '0;
    end else begin
      for (int s = 0; s < NS; s++) begin
        if (edge_w[s] & act_q[s]) begin
          sel_q[s] <= ~sel_q[s];
        end
      end
    end
  end

  // owed fetches: one per unit while running; a new set beats a clear
  always_comb begin
    for (int s = 0; s < NS; s++) begin
      pend_set[s] = edge_w[s] & rm_q[s][`SHF_RQ_ACT]
                    & is_fetching(cfg_type(pm_q[pm_idx(3'(s), `SHF_PMW_CFG)]));
      pend_clr[s] = (fst_q == shf_pkg::F_IDLE) & (fspr_q == 3'(s)) & pend_q[s];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q & ~pend_clr) | pend_set;
    end
  end

  // fetch sequencer: pick next owed spreader in round-robin order, take one header word, write it
  assign fifo_pop = (fst_q == shf_pkg::F_WAIT) & fifo_valid;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fst_q <= shf_pkg::F_IDLE;
      fspr_q <= '0;
      fword_q <= 32'h0000_0000;
      o_fetch_req <= 1'b0;
      o_fetch_spr <= '0;
    end else begin
      o_fetch_req <= 1'b0;
      case (fst_q)
        shf_pkg::F_IDLE: begin
          // round of the candidate pointer until an owed one is seen
          if (pend_q[fspr_q]) begin
            o_fetch_req <= 1'b1;
            o_fetch_spr <= fspr_q;
            fst_q <= shf_pkg::F_WAIT;
          end else begin
            fspr_q <= 3'(fspr_q + 3'h1);
          end
        end
        shf_pkg::F_WAIT: begin
          // header stalls here until input memory delivers
          if (fifo_valid) begin
            fword_q <= fifo_data;
            fst_q <= shf_pkg::F_WRITE;
          end
        end
        shf_pkg::F_WRITE: begin
          fst_q <= shf_pkg::F_IDLE;
        end
        default: fst_q <= shf_pkg::F_IDLE;
      endcase
    end
  end

  // header write goes to the idle bank, merging only the type's fields
  assign hdr_wr = (fst_q == shf_pkg::F_WRITE);
  assign hdr_addr = pm_idx(fspr_q, sel_q[fspr_q] ? `SHF_PMW_BANK0 : `SHF_PMW_BANK1);
  always_comb begin
    hdr_val = (pm_q[hdr_addr] & ~hdr_mask(cfg_type(pm_q[pm_idx(fspr_q, `SHF_PMW_CFG)])))
              | (fword_q & hdr_mask(cfg_type(pm_q[pm_idx(fspr_q, `SHF_PMW_CFG)])));
  end

  // apb decode
  assign a12 = i_paddr[11:0];
  assign hi_zero = (i_paddr[31:12] == 20'h00000) & (i_paddr[1:0] == 2'b00);
  assign apb_acc = i_psel & i_penable & ~o_pready;
  assign sw_pm_wr = apb_acc & i_pwrite & hi_zero & (a12 <= `SHF_PM_LAST);
  assign sw_rm_wr = apb_acc & i_pwrite & hi_zero & (a12 >= `SHF_RM_BASE) & (a12 <= `SHF_RM_LAST);
  assign stall = sw_pm_wr & hdr_wr;
  assign map_ok = hi_zero & ((a12 <= `SHF_RM_LAST) | (a12 == `SHF_A_STAT) | (a12 == `SHF_A_BANK));

  // read mux; status words show live sequencing state
  always_comb begin
    rd_val = 32'h0000_0000;
    if (a12 <= `SHF_PM_LAST) begin
      rd_val = pm_q[a12[7:2]];
    end else if (a12 <= `SHF_RM_LAST) begin
      rd_val = rm_q[a12[4:2]];
    end else if (a12 == `SHF_A_STAT) begin
      rd_val = {16'h0000, pend_q, act_q};
    end else if (a12 == `SHF_A_BANK) begin
      rd_val = {24'h000000, sel_q};
    end
  end

  // apb answer: one wait state, one more when the memory port is taken
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= apb_acc & ~stall;
      o_pslverr <= apb_acc & ~stall & ~map_ok;
      if (apb_acc & ~stall & ~i_pwrite) begin
        o_prdata <= map_ok ? rd_val : 32'h0000_0000;
      end
    end
  end

  // single write port: header first, held software write lands next cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < `SHF_PM_DEPTH; i++) begin
        pm_q[i] <= 32'h0000_0000;
      end
    end else if (hdr_wr) begin
      pm_q[hdr_addr] <= hdr_val;
    end else if (sw_pm_wr) begin
      pm_q[a12[7:2]] <= i_pwdata;
    end
  end

  // request memory, software only
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < `SHF_RM_DEPTH; i++) begin
        rm_q[i] <= 32'h0000_0000;
      end
    end else if (sw_rm_wr) begin
      rm_q[a12[4:2]] <= i_pwdata;
    end
  end

  // datapath controls; HS-PDSCH takes gain and weights from its group's dummy
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_spr_active <= '0;
      o_spr_dual <= '0;
      o_sttd_en <= '0;
      o_spr_gain <= '0;
      o_spr_weight <= '0;
      o_hdr_cur <= '0;
    end else begin
      o_spr_active <= act_q;
      o_spr_dual <= dual_q;
      for (int s = 0; s < NS; s++) begin
        logic [31:0] cfg;
        logic [31:0] cur;
        logic [15:0] g;
        logic [31:0] wt;
        logic found;
        cfg = pm_q[pm_idx(3'(s), `SHF_PMW_CFG)];
        cur = pm_q[pm_idx(3'(s), sel_q[s] ? `SHF_PMW_BANK1 : `SHF_PMW_BANK0)];
        g = pm_q[pm_idx(3'(s), `SHF_PMW_GAIN)][`SHF_GAIN_F];
        wt = pm_q[pm_idx(3'(s), `SHF_PMW_WGT)];
        found = 1'b0;
        if (hdr_gain(cfg_type(cfg))) begin
          g = cur[`SHF_HDR_HI];
        end
        if (cfg_type(cfg) == shf_pkg::CH_HSPDSCH) begin
          // lowest-numbered dummy of the same group wins, so the group shares one set
          for (int d = 0; d < NS; d++) begin
            if (!found && cfg_type(pm_q[pm_idx(3'(d), `SHF_PMW_CFG)]) == shf_pkg::CH_DUMMY
                && pm_q[pm_idx(3'(d), `SHF_PMW_CFG)][`SHF_CFG_GRP] == cfg[`SHF_CFG_GRP]) begin
              found = 1'b1;
              g = pm_q[pm_idx(3'(d), `SHF_PMW_GAIN)][`SHF_GAIN_F];
              wt = pm_q[pm_idx(3'(d), `SHF_PMW_WGT)];
            end
          end
        end
        o_sttd_en[s] <= (cfg_type(cfg) == shf_pkg::CH_PCCPCH) & cfg[`SHF_CFG_DIV] & dual_q[s];
        o_spr_gain[s*16 +: 16] <= g;
        o_spr_weight[s*32 +: 32] <= wt;
        o_hdr_cur[s*32 +: 32] <= cur;
      end
    end
  end
endmodule // shf_top

// ### shf_cfg.svh
`ifndef SHF_CFG_SVH
`define SHF_CFG_SVH
// array size
`define SHF_NSPR 8
`define SHF_SPR_W 3
`define SHF_PM_DEPTH 64
`define SHF_RM_DEPTH 8
// parameter memory word slots within one spreader
`define SHF_PMW_CFG 3'h0
`define SHF_PMW_GAIN 3'h1
`define SHF_PMW_TIM 3'h2
`define SHF_PMW_WGT 3'h3
`define SHF_PMW_BANK0 3'h4
`define SHF_PMW_BANK1 3'h5
// configuration word fields
`define SHF_CFG_TYPE 4:0
`define SHF_CFG_DIV 5
`define SHF_CFG_GRP 10:8
`define SHF_TIM_OFS 7:0
`define SHF_GAIN_F 15:0
// request memory fields
`define SHF_RQ_ACT 0
`define SHF_RQ_DUAL 1
// header word field masks
`define SHF_HM_DTX 32'h0000_0001
`define SHF_HM_DIV 32'h0000_0002
`define SHF_HM_MOD 32'h0000_000C
`define SHF_HM_CMT 32'h0000_0030
`define SHF_HM_NBP 32'h0000_FFC0
`define SHF_HM_HI 32'hFFFF_0000
`define SHF_HDR_HI 31:16
// chip timing
`define SHF_FRAME_MS 10
`define SHF_SUBFRAME_MS 2
`define SHF_FRAME_CHIPS 16'h9600
`define SHF_SUBFRAME_CHIPS (16'(`SHF_FRAME_CHIPS / (`SHF_FRAME_MS / `SHF_SUBFRAME_MS)))
`define SHF_ASLOT_CHIPS 16'h1400
`define SHF_OFS_UNIT 16'h0100
// register map, byte addresses
`define SHF_PM_BASE 12'h000
`define SHF_PM_LAST 12'h0FF
`define SHF_RM_BASE 12'h100
`define SHF_RM_LAST 12'h11F
`define SHF_A_STAT 12'h120
`define SHF_A_BANK 12'h124
`endif

// ### shf_pkg.sv
package shf_pkg;
  // channel type held in the configuration word
  typedef enum logic [4:0] {
    CH_PSCH, CH_SSCH, CH_PCPICH, CH_SCPICH, CH_AICH, CH_EAICH, CH_PCCPCH, CH_SCCPCH,
    CH_PICH, CH_MICH, CH_DPCH, CH_FDPCH, CH_HSPDSCH, CH_HSSCCH, CH_EHICH, CH_EAGCH,
    CH_DUMMY
  } shf_chan_t;
  // header fetch sequencer
  typedef enum logic [1:0] {F_IDLE, F_WAIT, F_WRITE} shf_fetch_st_t;
endpackage

// ### shf_hdr_src.sv
`timescale 1ns/1ns
// software side: header words prepared in input memory, offered in unit order
module shf_hdr_src #(
  parameter int GAP = 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // word stream toward the fetch buffer
  input wire logic i_ready,
  input wire logic i_hold, // stimulus gate: no new word offered while high
  output logic o_valid,
  output logic [31:0] o_data
);
  logic [31:0] q [$]; // one header word per unit, payload not modelled
  int gap_q; // idle cycles before the next word, keeps the model slow
  // queue one prepared header
  task automatic push(input logic [31:0] w);
    q.push_back(w);
  endtask
  // offer words in order; an idle bus alternates between the old word and its inverse
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_valid <= 1'b0;
      o_data <= 32'h0;
      gap_q <= 0;
    end else if (o_valid && i_ready) begin
      // word taken, release the bus
      o_valid <= 1'b0;
      o_data <= ~o_data;
      gap_q <= GAP;
    end else if (!o_valid && gap_q == 0 && q.size() > 0 && !i_hold) begin
      // next header, held until taken
      o_valid <= 1'b1;
      o_data <= q.pop_front();
    end else if (!o_valid) begin
      // idle: invert the bus each cycle, so the old word returns every second idle cycle
      o_data <= ~o_data;
      gap_q <= (gap_q > 0) ? gap_q - 1 : 0;
    end
  end
endmodule // shf_hdr_src

// ### shf_top_properties.sv
`timescale 1ns/1ns
`include "shf_cfg.svh"
module shf_top_properties (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // apb side
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  // fetch and datapath controls
  input wire logic o_fetch_req,
  input wire logic [`SHF_SPR_W-1:0] o_fetch_spr,
  input wire logic [`SHF_NSPR-1:0] o_spr_active,
  input wire logic [`SHF_NSPR-1:0] o_spr_dual,
  input wire logic [`SHF_NSPR-1:0] o_sttd_en
);
  // one clock domain
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // first edge of an access phase
  sequence s_access;
    i_psel && $rose(i_penable);
  endsequence
  // a one-cycle answer
  sequence s_answer;
    o_pready ##1 !o_pready;
  endsequence
  // answer in one cycle, two when the header write owns the port
  a_ready_bound: assert property (s_access |-> ##[1:2] o_pready)
    else $error("apb answer late");
  a_ready_pulse: assert property (o_pready |-> s_answer)
    else $error("pready longer than one cycle");
  a_ready_in_access: assert property (o_pready |-> i_psel && i_penable)
    else $error("pready outside access phase");
  a_slverr_with_ready: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  a_prdata_hold: assert property (!$stable(o_prdata) |-> o_pready && !i_pwrite)
    else $error("read data moved without a read");
  // a fetch is a single strobe and only for a running spreader
  a_fetch_pulse: assert property (o_fetch_req |=> !o_fetch_req)
    else $error("fetch strobe too long");
  a_fetch_active: assert property (o_fetch_req |-> o_spr_active[o_fetch_spr])
    else $error("fetch for an idle spreader");
  a_fetch_id_hold: assert property (!$stable(o_fetch_spr) |-> o_fetch_req)
    else $error("fetch id moved without a fetch");
  // secondary stream only on a two-stream spreader
  a_sttd_dual: assert property (o_sttd_en != '0 |-> (o_sttd_en & ~o_spr_dual) == '0)
    else $error("diversity on a single-stream spreader");
endmodule // shf_top_properties

bind shf_top shf_top_properties u_props (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
  .o_fetch_req(o_fetch_req), .o_fetch_spr(o_fetch_spr), .o_spr_active(o_spr_active),
  .o_spr_dual(o_spr_dual), .o_sttd_en(o_sttd_en)
);

// ### shf_top_tb_top.sv
`timescale 1ns/1ns
`include "shf_cfg.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_errors++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module shf_top_tb_top;
  // clock, reset and apb master
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [31:0] i_paddr = 32'h0;
  logic [31:0] i_pwdata = 32'h0;
  logic i_chip_tick = 1'b0;
  // design outputs and header stream
  logic o_pready, o_pslverr, o_hdr_ready, o_fetch_req, i_hdr_valid;
  logic [31:0] o_prdata, i_hdr_data;
  logic [`SHF_SPR_W-1:0] o_fetch_spr;
  logic [`SHF_NSPR-1:0] o_spr_active, o_spr_dual, o_sttd_en;
  logic [`SHF_NSPR*16-1:0] o_spr_gain;
  logic [`SHF_NSPR*32-1:0] o_spr_weight, o_hdr_cur;
  // bookkeeping
  int n_errors = 0;
  int n_tests = 0;
  int fetch0 = 0; // fetches seen for the pilot spreader
  int c;
  logic [31:0] rd;
  logic er;
  logic src_hold = 1'b1; // headers held back until a scenario lets them go
  int cyc = 0; // free cycle count, read as the value before each edge
  int t1 = 0; // cycle of the last fetch of spreader 1
  always @(posedge i_clk) cyc <= cyc + 1;
  localparam logic [31:0] HCOPY = 32'hFFFF_FFCF; // fields an HS-PDSCH header overwrites
  logic [31:0] hdr [0:8] = '{32'hA5C1_1F35, 32'h5A3E_2076, 32'hC3A4_40B1, 32'h0000_0030,
    32'h0000_0031, 32'h0000_0032, 32'h0000_0033, 32'h0000_0034, 32'h0000_0035};
  // 100 MHz
  always #5 i_clk = ~i_clk;
  shf_top uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
    .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_chip_tick(i_chip_tick),
    .i_hdr_valid(i_hdr_valid), .i_hdr_data(i_hdr_data), .o_hdr_ready(o_hdr_ready),
    .o_fetch_req(o_fetch_req), .o_fetch_spr(o_fetch_spr), .o_spr_active(o_spr_active),
    .o_spr_dual(o_spr_dual), .o_sttd_en(o_sttd_en), .o_spr_gain(o_spr_gain),
    .o_spr_weight(o_spr_weight), .o_hdr_cur(o_hdr_cur));
  shf_hdr_src u_src (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ready(o_hdr_ready), .i_hold(src_hold),
    .o_valid(i_hdr_valid), .o_data(i_hdr_data));
  // one apb transfer; waits for pready with no assumed latency
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 50);
    rd = o_prdata;
    er = o_pslverr;
    if (n >= 50) begin
      n_errors++;
      $display("[ERR] apb answer expected 1 seen 0");
    end
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  // read and compare the masked word
  task automatic rchk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] ex,
    input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, ex & m, rd & m)
  endtask
  // wait for a fetch of spreader 1, bounded; c is its spacing from the last one
  task automatic wait_fetch(input int lim);
    int t0;
    t0 = cyc;
    do begin
      @(posedge i_clk);
    end while (!(o_fetch_req === 1'b1 && o_fetch_spr === 3'h1) && cyc - t0 < lim);
    c = cyc - t1;
    t1 = cyc;
  endtask
  // pilot spreader must never fetch
  always @(posedge i_clk) if (o_fetch_req === 1'b1 && o_fetch_spr === 3'h0) fetch0++;
  // verdict, reached from the tests or the watchdog
  task automatic end_of_test;
    if (n_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // watchdog: run needs about 38400 cycles
  initial begin
    repeat (95000) @(posedge i_clk);
    n_errors++;
    end_of_test();
  end
  // main sequence
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    i_chip_tick <= 1'b1;
    rchk(`SHF_A_STAT, 32'hFFFF_FFFF, 32'h0, "status");
    // unmapped and unaligned places are refused
    rchk(32'h0000_0200, 32'hFFFF_FFFF, 32'h0, "unmapped");
    `CHK("slverr", 1'b1, er)
    rchk(32'h0000_0002, 32'hFFFF_FFFF, 32'h0, "unaligned");
    `CHK("slverr", 1'b1, er)
    // read-only status ignores writes
    apb(1'b1, `SHF_A_STAT, 32'hFFFF_FFFF);
    rchk(`SHF_A_STAT, 32'h0000_00FF, 32'h0, "status ro");
    // pilot on 0, HS-PDSCH on 1, both at offset 0 so neighbours match
    apb(1'b1, 32'h0000_0000, 32'(shf_pkg::CH_PCPICH));
    apb(1'b1, 32'h0000_0020, 32'(shf_pkg::CH_HSPDSCH));
    apb(1'b1, 32'h0000_0024, 32'h0000_4321);
    rchk(32'h0000_0020, 32'h0000_001F, 32'(shf_pkg::CH_HSPDSCH), "cfg1");
    apb(1'b1, 32'h0000_0100, 32'h0000_0003);
    apb(1'b1, 32'h0000_0104, 32'h0000_0001);
    wait_fetch(9000);
    // first header released late so its bank write meets a software write
    u_src.push(hdr[0]);
    src_hold <= 1'b0;
    @(posedge i_clk);
    apb(1'b1, 32'h0000_0044, 32'h0000_1111);
    rchk(32'h0000_0044, 32'h0000_FFFF, 32'h0000_1111, "gain2 hit");
    rchk(32'h0000_0034, HCOPY, hdr[0], "bank1 hit");
    // fill the header buffer until it refuses
    for (int i = 1; i < 9; i++) u_src.push(hdr[i]);
    repeat (40) @(posedge i_clk);
    `CHK("hdr_ready", 1'b0, o_hdr_ready)
    // pilot is frame based, so only spreader 1 runs yet
    `CHK("active", 8'h02, o_spr_active)
    `CHK("dual", 2'b00, o_spr_dual[1:0])
    rchk(`SHF_A_STAT, 32'h0000_00FF, 32'h0000_0002, "status act");
    // one fetch a sub-frame; a software write each sub-frame, landing clear of the header write cycle
    for (int k = 0; k < 3; k++) begin
      fork
        begin
          repeat (7678 - 9) @(posedge i_clk);
          apb(1'b1, 32'h0000_0044, 32'h0000_1230 + k);
          rchk(32'h0000_0044, 32'h0000_FFFF, 32'h0000_1230 + k, "gain2");
        end
        wait_fetch(8000);
      join
      // the id scan lets a fetch trail its boundary by less than one round
      `CHK("unit", 1, (c + `SHF_NSPR) / 7680)
      `CHK("hdr_cur", hdr[k] & HCOPY, o_hdr_cur[63:32] & HCOPY)
      `CHK("cm kept", 2'b00, o_hdr_cur[37:36])
    end
    rchk(32'h0000_0024, 32'h0000_FFFF, 32'h0000_4321, "gain1");
    `CHK("own gain", 16'h4321, o_spr_gain[31:16])
    // stop 1, start P-CCPCH with diversity on 3
    apb(1'b1, 32'h0000_0104, 32'h0000_0000);
    apb(1'b1, 32'h0000_0060, 32'h0000_0020 | 32'(shf_pkg::CH_PCCPCH));
    apb(1'b1, 32'h0000_010C, 32'h0000_0003);
    c = 0;
    while (o_sttd_en[3] !== 1'b1 && c < 40000) begin
      @(posedge i_clk);
      c++;
    end
    `CHK("sttd", 1'b1, o_sttd_en[3])
    // frame boundary passed: pilot and P-CCPCH run with two streams, 1 stopped
    `CHK("active", 8'h09, o_spr_active)
    `CHK("dual", 8'h09, o_spr_dual)
    `CHK("pilot fetch", 0, fetch0)
    end_of_test();
  end
endmodule // shf_top_tb_top
